// file: include/usync_defs.svh
`ifndef USYNC_DEFS_SVH
`define USYNC_DEFS_SVH
// byte addresses on apb
`define USYNC_RECEIVE_CONTROL_STATUS_OFF 8'h18
`define USYNC_TRANSMIT_CONTROL_STATUS_OFF 8'h98
`define USYNC_TXDATA_OFF 8'h9c
`define USYNC_RXDATA_OFF 8'h1c
`define USYNC_INTCTL_OFF 8'h20
`define USYNC_PINDIR_OFF 8'h24
// transmit_control_status bits
`define USYNC_TX_CLOCK_SOURCE_SELECT 7
`define USYNC_TX_TX9 6
`define USYNC_TX_EN 5
`define USYNC_TX_SYNC 4
`define USYNC_TX_HIGH_BAUD_SELECT 2
`define USYNC_TX_EMPTY 1
`define USYNC_TX_D9 0
// receive_control_status bits
`define USYNC_RX_SERIAL_PORT_ENABLE 7
`define USYNC_RX_RX9 6
`define USYNC_RX_SINGLE_RECEIVE_ENABLE 5
`define USYNC_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define USYNC_RX_ADDRESS_DETECT_ENABLE 3
`define USYNC_RX_FRAMING_ERROR_FLAG 2
`define USYNC_RX_OVERRUN_ERROR_FLAG 1
`define USYNC_RX_D9 0
// interrupt control/status bits
`define USYNC_IC_TX_BUFFER_FREE_FLAG 0
`define USYNC_IC_RX_WORD_READY_FLAG 1
`define USYNC_IC_TX_INTERRUPT_ENABLE 2
`define USYNC_IC_RX_INTERRUPT_ENABLE 3
`define USYNC_IC_GIE 4
`define USYNC_IC_SLEEP 5
`define USYNC_TRANSMIT_CONTROL_STATUS_RST 8'h02
`define USYNC_RECEIVE_CONTROL_STATUS_RST 8'h00
`define USYNC_PINDIR_RST 8'hc0
`endif

// file: include/usync_pkg.sv
`default_nettype none
package usync_pkg;
  typedef enum logic [2:0] {
    USYNC_IDLE = 3'b001,
    USYNC_TX = 3'b010,
    USYNC_RX = 3'b100
  } usync_mode_t;
  typedef struct packed {
    logic [7:0] transmit_control_status;
    logic [7:0] receive_control_status;
    logic [7:0] pindir;
    logic tx_interrupt_enable;
    logic rx_interrupt_enable;
    logic gie;
    logic sleep;
    logic tx_buffer_free_flag;
    logic rx_word_ready_flag;
    logic [7:0] thr;
    logic thr_d9;
    logic [8:0] transmit_shift_register;
    logic tsr_full;
    logic [8:0] receive_shift_register;
    logic [7:0] rhr;
    logic rhr_d9;
    logic [3:0] bitcnt;
    usync_mode_t mode;
    logic [2:0] ck_sync;
    logic [2:0] dt_sync;
    logic ck_q;
    logic dt_q;
    logic dt_out;
    logic dt_oe;
    logic wake;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hbaud;
  } usync_state_t;
endpackage
`default_nettype wire

// file: src/usync_slave.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usync_defs.svh"
// Notes on behaviour
// - clocked mode bit: 1 sync, 0 async
// - pins active: port enable, both inputs
// - continuous receive enable beats transmit in sync
// - shift empty flag read-only, resets 1
// - nine-bit transmit uses tx ninth bit
// - receiver takes nine or eight bits
// - master single receive self-clears after word
// - continuous receive runs until cleared
// - address detect loads only ninth-bit-set words, async nine-bit only
// - no address detect: all words, ninth passed
// - framing flag updated with next word
// - overrun set on overrun, cleared with continuous
// - slave shifts on external clock, even asleep
// - second word waits, buffer flag stays clear
// - hand over second word, then set flag
// - transmit interrupt wakes, vectors if global
// - single receive ignored in slave
// - word received asleep loads, may wake
// - word done sets ready flag, interrupt
module usync_slave
  import usync_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shift_clock_in,
  input wire logic serial_line_in,
  output logic serial_line_out,
  output logic serial_line_oe,
  output logic wake_request,
  output logic interrupt_request,
  output logic high_baud_active
);

  usync_state_t r, next_r;

  logic wr, rd, sync_mode, slave_mode, pins_on, ck_rise, ck_fall, dt_now;
  logic rx_on, word_len9;

  assign wr = psel & penable & pwrite & ~r.pready;
  assign rd = psel & penable & ~pwrite & ~r.pready;
  assign sync_mode = r.transmit_control_status[`USYNC_TX_SYNC];
  assign slave_mode = sync_mode & ~r.transmit_control_status[`USYNC_TX_CLOCK_SOURCE_SELECT];
  assign pins_on = r.receive_control_status[`USYNC_RX_SERIAL_PORT_ENABLE] & (&r.pindir[7:6]);
  // only stages 2 and 3 are compared; stage 1 may be metastable
  assign ck_rise = r.ck_sync[1] & r.ck_sync[2] & ~r.ck_q;
  assign ck_fall = ~r.ck_sync[1] & ~r.ck_sync[2] & r.ck_q;
  assign dt_now = (r.dt_sync[1] == r.dt_sync[2]) ? r.dt_sync[2] : r.dt_q;
  // single receive is a don't care in slave mode
  assign rx_on = r.receive_control_status[`USYNC_RX_CONTINUOUS_RECEIVE_ENABLE];
  assign word_len9 = r.receive_control_status[`USYNC_RX_RX9];

  always_comb begin
    logic [3:0] last_bit;
    logic accept;
    logic pending;
    next_r = r;
    last_bit = 4'h0;
    accept = 1'b0;
    pending = 1'b0;
    next_r.ck_sync = {r.ck_sync[1:0], shift_clock_in};
    next_r.dt_sync = {r.dt_sync[1:0], serial_line_in};
    if (r.ck_sync[1] == r.ck_sync[2]) begin
      next_r.ck_q = r.ck_sync[2];
    end
    next_r.dt_q = dt_now;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel & penable & ~r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0;
      unique case (paddr)
        `USYNC_TRANSMIT_CONTROL_STATUS_OFF: begin
          next_r.prdata[7:0] = {r.transmit_control_status[7:4], 1'b0, r.transmit_control_status[2], ~r.tsr_full, r.transmit_control_status[0]};
          if (wr) begin
            next_r.transmit_control_status = {pwdata[7:4], 1'b0, pwdata[2], r.transmit_control_status[1], pwdata[0]};
          end
        end
        `USYNC_RECEIVE_CONTROL_STATUS_OFF: begin
          next_r.prdata[7:0] = r.receive_control_status;
          if (wr) begin
            next_r.receive_control_status[7:3] = pwdata[7:3];
            if (~pwdata[`USYNC_RX_CONTINUOUS_RECEIVE_ENABLE]) begin
              next_r.receive_control_status[`USYNC_RX_OVERRUN_ERROR_FLAG] = 1'b0;
            end
          end
        end
        `USYNC_TXDATA_OFF: begin
          next_r.prdata[7:0] = r.thr;
          if (wr) begin
            next_r.thr = pwdata[7:0];
            next_r.thr_d9 = r.transmit_control_status[`USYNC_TX_D9];
            next_r.tx_buffer_free_flag = 1'b0;
          end
        end
        `USYNC_RXDATA_OFF: begin
          next_r.prdata[7:0] = r.rhr;
          if (rd) begin
            next_r.rx_word_ready_flag = 1'b0;
          end
        end
        `USYNC_INTCTL_OFF: begin
          next_r.prdata[5:0] = {r.sleep, r.gie, r.rx_interrupt_enable, r.tx_interrupt_enable, r.rx_word_ready_flag, r.tx_buffer_free_flag};
          if (wr) begin
            next_r.tx_interrupt_enable = pwdata[`USYNC_IC_TX_INTERRUPT_ENABLE];
            next_r.rx_interrupt_enable = pwdata[`USYNC_IC_RX_INTERRUPT_ENABLE];
            next_r.gie = pwdata[`USYNC_IC_GIE];
            next_r.sleep = pwdata[`USYNC_IC_SLEEP];
          end
        end
        `USYNC_PINDIR_OFF: begin
          next_r.prdata[7:0] = r.pindir;
          if (wr) begin
            next_r.pindir = pwdata[7:0];
          end
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    // holding register to shift register; set flag only after transfer
    if (~r.tx_buffer_free_flag & ~r.tsr_full & r.transmit_control_status[`USYNC_TX_EN]) begin
      next_r.transmit_shift_register = {r.thr_d9, r.thr};
      next_r.tsr_full = 1'b1;
      next_r.tx_buffer_free_flag = 1'b1;
    end
    if (~pins_on | ~slave_mode) begin
      next_r.mode = USYNC_IDLE;
      next_r.dt_oe = 1'b0;
      next_r.bitcnt = 4'h0;
    end else begin
      unique case (r.mode)
        USYNC_IDLE: begin
          next_r.bitcnt = 4'h0;
          if (rx_on) begin
            next_r.mode = USYNC_RX;
            next_r.dt_oe = 1'b0;
          end else if (r.tsr_full & r.transmit_control_status[`USYNC_TX_EN]) begin
            next_r.mode = USYNC_TX;
            next_r.dt_oe = 1'b1;
            next_r.dt_out = r.transmit_shift_register[0];
          end else begin
            next_r.dt_oe = 1'b0;
          end
        end
        USYNC_TX: begin
          last_bit = r.transmit_control_status[`USYNC_TX_TX9] ? 4'h8 : 4'h7;
          if (rx_on) begin
            next_r.mode = USYNC_IDLE;
            next_r.dt_oe = 1'b0;
          end else if (ck_rise) begin
            // data changes on falling, master samples on rising
            if (r.bitcnt == last_bit) begin
              next_r.tsr_full = 1'b0;
              next_r.mode = USYNC_IDLE;
            end else begin
              next_r.bitcnt = r.bitcnt + 4'h1;
            end
          end else if (ck_fall) begin
            next_r.dt_out = r.transmit_shift_register[r.bitcnt];
          end
        end
        USYNC_RX: begin
          next_r.dt_oe = 1'b0;
          last_bit = word_len9 ? 4'h8 : 4'h7;
          if (~rx_on) begin
            next_r.mode = USYNC_IDLE;
          end else if (ck_fall) begin
            next_r.receive_shift_register[r.bitcnt] = dt_now;
            if (r.bitcnt == last_bit) begin
              next_r.bitcnt = 4'h0;
              if (~word_len9) begin
                next_r.receive_shift_register[8] = 1'b0;
              end
              accept = 1'b1;
            end else begin
              next_r.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        default: begin
          next_r.mode = USYNC_IDLE;
        end
      endcase
    end
    // address detect only filters nine-bit async words
    if (~sync_mode & word_len9 & r.receive_control_status[`USYNC_RX_ADDRESS_DETECT_ENABLE] & ~next_r.receive_shift_register[8]) begin
      accept = 1'b0;
    end
    if (accept) begin
      // address detect is an async feature; sync accepts all
      if (r.rx_word_ready_flag) begin
        next_r.receive_control_status[`USYNC_RX_OVERRUN_ERROR_FLAG] = 1'b1;
      end else begin
        next_r.rhr = next_r.receive_shift_register[7:0];
        next_r.rhr_d9 = next_r.receive_shift_register[8];
        next_r.receive_control_status[`USYNC_RX_D9] = next_r.receive_shift_register[8];
        next_r.receive_control_status[`USYNC_RX_FRAMING_ERROR_FLAG] = 1'b0;
        next_r.rx_word_ready_flag = 1'b1;
      end
    end
    // an accepted word also clears single receive in master mode
    if (sync_mode & r.transmit_control_status[`USYNC_TX_CLOCK_SOURCE_SELECT] & accept) begin
      next_r.receive_control_status[`USYNC_RX_SINGLE_RECEIVE_ENABLE] = 1'b0;
    end
    pending = (next_r.tx_buffer_free_flag & next_r.tx_interrupt_enable) | (next_r.rx_word_ready_flag & next_r.rx_interrupt_enable);
    // global enable gates the core's line, never the wake
    next_r.irq = pending & next_r.gie;
    next_r.wake = pending & r.sleep;
    if (next_r.wake & ~r.gie) begin
      next_r.sleep = 1'b0;
    end
    next_r.hbaud = next_r.transmit_control_status[`USYNC_TX_HIGH_BAUD_SELECT] & ~next_r.transmit_control_status[`USYNC_TX_SYNC];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.transmit_control_status <= `USYNC_TRANSMIT_CONTROL_STATUS_RST;
      r.receive_control_status <= `USYNC_RECEIVE_CONTROL_STATUS_RST;
      r.pindir <= `USYNC_PINDIR_RST;
      r.tx_buffer_free_flag <= 1'b1;
      r.mode <= USYNC_IDLE;
      // shift clock idles high; avoids a false edge after reset
      r.ck_sync <= 3'h7;
      r.ck_q <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign serial_line_out = r.dt_out;
  assign serial_line_oe = r.dt_oe;
  assign wake_request = r.wake;
  assign interrupt_request = r.irq;
  // baud divisor select only steers async timing, out of this block
  assign high_baud_active = r.hbaud;

endmodule
`default_nettype wire

// file: sim/usync_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module usync_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic shift_clock_in,
  input wire logic serial_line_out,
  input wire logic serial_line_oe,
  input wire logic wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [3:0] since_fall;
  wire logic mapped = paddr inside {8'h18, 8'h98, 8'h1c, 8'h9c, 8'h20, 8'h24};
  // saturates, so an idle-time data change is caught
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) since_fall <= 4'hf;
    else if ($fell(shift_clock_in)) since_fall <= 4'h0;
    else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
  end
  property p_ack; psel && penable && !$past(penable) |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("late pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long pready");
  property p_rise; $rose(pready) |-> $past(psel && penable); endproperty
  a_rise: assert property (p_rise) else $error("stray pready");
  property p_only; pready |-> psel && penable; endproperty
  a_only: assert property (p_only) else $error("pready idle");
  property p_err; pslverr |-> pready && !mapped; endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_ok; pready && !mapped |-> pslverr; endproperty
  a_ok: assert property (p_ok) else $error("no pslverr");
  property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_shift;
    serial_line_oe && $past(serial_line_oe) && $changed(serial_line_out) |-> since_fall != 4'hf;
  endproperty
  a_shift: assert property (p_shift) else $error("data moved idle");
  c_err: cover property (pslverr);
  c_wake: cover property ($rose(wake_request));
  c_tx: cover property ($rose(serial_line_oe));
endmodule
bind usync_slave usync_monitor mon (.*);
`default_nettype wire

// file: sim/usync_peer.sv
`timescale 1ns/1ps
`default_nettype none
module usync_peer (
  input wire logic clk,
  input wire logic line,
  output logic ck,
  output logic dt
);
  // clock idles high and stands still between words
  initial begin
    ck = 1'b1;
    dt = 1'b0;
  end
  task automatic xfer(input logic [8:0] w, input int n, output logic [8:0] r);
    r = 9'h0;
    // 320 ns per bit: 3 clk high, 5 clk low; line sampled at the rise
    for (int i = 0; i < n; i++) begin
      dt <= w[i];
      @(posedge clk);
      ck <= 1'b0;
      repeat (5) @(posedge clk);
      r[i] = line;
      ck <= 1'b1;
      repeat (2) @(posedge clk);
    end
    // quiet time so the last edge clears the block's synchroniser
    repeat (4) @(posedge clk);
    dt <= ~dt;
  endtask
endmodule
`default_nettype wire

// file: sim/usync_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usync_slave_bench;
  logic clk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic sl_out, sl_oe, wake, irq, hb, pk, pd;
  logic [8:0] w;
  int errors = 0;
  int n_tests = 0;
  wire logic line = sl_oe ? sl_out : pd;
  always #20 clk = ~clk;
  usync_slave uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock_in(pk), .serial_line_in(line), .serial_line_out(sl_out),
    .serial_line_oe(sl_oe), .wake_request(wake), .interrupt_request(irq),
    .high_baud_active(hb));
  usync_peer peer (.clk(clk), .line(line), .ck(pk), .dt(pd));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask
  task automatic summarize;
    $display("%0d mismatches in %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h98, 32'h02, "transmit_control_status");
    rd(8'h18, 32'h00, "receive_control_status");
    rd(8'h24, 32'hc0, "pindir");
    rd(8'h20, 32'h01, "intctl");
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    apb(1'b1, 8'h98, 32'h04);
    chk("high_baud_select async", {31'h0, hb}, 32'h1);
    $display("reset test done");
    apb(1'b1, 8'h18, 32'h80);
    apb(1'b1, 8'h98, 32'h14);
    chk("high_baud_select sync", {31'h0, hb}, 32'h0);
    apb(1'b1, 8'h20, 32'h04);
    apb(1'b1, 8'h98, 32'h71);
    apb(1'b1, 8'h9c, 32'ha5);
    apb(1'b1, 8'h98, 32'h70);
    apb(1'b1, 8'h9c, 32'h5a);
    // sleep only after both words, as the buffer-empty flag is pending before
    apb(1'b1, 8'h20, 32'h24);
    rd(8'h20, 32'h24, "tx_buffer_free_flag held");
    rd(8'h98, 32'h70, "tsr full");
    peer.xfer(9'h155, 9, w);
    chk("word1", {23'h0, w}, 32'h1a5);
    rd(8'h20, 32'h05, "tx_buffer_free_flag woke");
    chk("irq off", {31'h0, irq}, 32'h0);
    rd(8'h98, 32'h70, "second in tsr");
    peer.xfer(9'h0aa, 9, w);
    chk("word2", {23'h0, w}, 32'h05a);
    rd(8'h98, 32'h72, "tsr empty");
    $display("transmit test done");
    apb(1'b1, 8'h20, 32'h38);
    apb(1'b1, 8'h98, 32'h30);
    apb(1'b1, 8'h18, 32'hf0);
    apb(1'b1, 8'h9c, 32'h77);
    peer.xfer(9'h13c, 9, w);
    chk("rx holds tx", {31'h0, sl_oe}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("wake", {31'h0, wake}, 32'h1);
    rd(8'h18, 32'hf1, "rx ninth");
    rd(8'h1c, 32'h3c, "rx data");
    apb(1'b1, 8'h18, 32'h90);
    peer.xfer(9'h0c3, 8, w);
    peer.xfer(9'h066, 8, w);
    rd(8'h18, 32'h92, "overrun");
    rd(8'h1c, 32'hc3, "kept word");
    apb(1'b1, 8'h18, 32'h80);
    rd(8'h18, 32'h80, "overrun off");
    $display("receive test done");
    summarize;
  end
  initial begin
    #300000;
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
